// *** rtl/rtac_cmp.v ***
// one angle comparator with optional chatter hysteresis
module rtac_cmp (
  // clock and reset
  input  wire        mclk_i,
  input  wire        reset_n_i,
  input  wire        ce_i,
  // angles
  input  wire [15:0] angle_i,
  input  wire [15:0] target_i,
  input  wire [15:0] mask_i,
  input  wire        hyst_en_i,
  // result
  output reg         match_o
);

  wire [15:0] diff;
  wire [11:0] diff12;
  wire        eq;
  wire        near;

  assign diff   = angle_i - target_i;
  assign diff12 = diff[15:4];
  assign eq     = ((angle_i ^ target_i) & mask_i) == 16'h0000;
  // leaving the match needs a step of two 12-bit codes, so one-code jitter cannot chatter
  assign near   = (diff12 == 12'h000) || (diff12 == 12'h001) || (diff12 == 12'hFFF);

  always @(posedge mclk_i)
  begin
    if (!reset_n_i)
      match_o <= 1'b0;
    else if (ce_i)
    begin
      if (hyst_en_i)
        match_o <= eq | (match_o & near);
      else
        match_o <= eq;
    end
  end

endmodule // rtac_cmp

// *** rtl/rtac_consts.vh ***
// constants for the resolver tracking auxiliary control block
`ifndef RTAC_CONSTS_VH
`define RTAC_CONSTS_VH

// register byte offsets
`define RTAC_EXC_CFG_OFS   8'h00
`define RTAC_LOOP_CFG_OFS  8'h04
`define RTAC_DIAG_CTL_OFS  8'h08
`define RTAC_ENC_CTL_OFS   8'h0C
`define RTAC_CMP_CTL_OFS   8'h10
`define RTAC_CMP0_OFS      8'h14
`define RTAC_CMP1_OFS      8'h18
`define RTAC_CMP2_OFS      8'h1C
`define RTAC_STATUS_OFS    8'h20

// reset values
`define RTAC_EXC_CFG_RST   2'h3
`define RTAC_RES_SEL_RST   3'h1
`define RTAC_ST_GAIN_RST   4'h4
`define RTAC_UP_CLAMP_RST  4'h7
`define RTAC_LO_CLAMP_RST  4'h0
`define RTAC_ENC_EN_RST    6'h00

// field positions
`define RTAC_DIAG_KICK     0
`define RTAC_DIAG_DIS      1
`define RTAC_ENC_IRQ_EN    6
`define RTAC_ENC_HYS_BYP   7
`define RTAC_ENC_LOCK      8
`define RTAC_CMP_LATCH     0

// gain codes: multiplier is two to the code
`define RTAC_GAIN_MAX      4'h7
`define RTAC_RES_12BIT     3'h1

// timing
`define RTAC_CLK_KHZ       10000
`define RTAC_FG_TIME_US    5000
`define RTAC_FG_STEP_US    500

`endif

// *** rtl/rtac_top.v ***
// forced gain sequencer, excitation select, angle compare and encoder pulses
//
// Our own choices: the register addresses and the APB register port.
`include "rtac_consts.vh"

module rtac_top #(
  parameter FG_CYCLES   = `RTAC_FG_TIME_US * (`RTAC_CLK_KHZ / 1000),
  parameter STEP_CYCLES = `RTAC_FG_STEP_US * (`RTAC_CLK_KHZ / 1000)
) (
  // clock, reset, enable
  input  wire        mclk_i,
  input  wire        reset_n_i,
  input  wire        ce_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // tracking loop and diagnostics events
  input  wire [15:0] angle_i,
  input  wire        angle_err_large_i,
  input  wire        err_recover_i,
  input  wire        conv_test_start_i,
  input  wire        conv_test_end_i,
  input  wire        short_test_end_i,
  input  wire        short_detect_end_i,
  // loop control
  output reg         forced_gain_phase_o,
  output reg  [3:0]  velocity_gain_o,
  output reg  [2:0]  resolution_select_o,
  // excitation
  output reg         excitation_out_en_o,
  output reg         extract_en_o,
  output reg         extract_use_recovered_o,
  // compare requests and encoder pulses
  output reg  [2:0]  cmp_req_o,
  output reg  [5:0]  enc_pulse_o
);

  localparam [19:0] FG_LOAD   = FG_CYCLES[19:0];
  localparam [19:0] STEP_LOAD = STEP_CYCLES[19:0];
  // bits of resolution for each select code
  function [4:0] res_bits;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    res_bits = 5'd10;
        3'h1:    res_bits = 5'd12;
        3'h2:    res_bits = 5'd13;
        3'h3:    res_bits = 5'd14;
        default: res_bits = 5'd16;
      endcase
    end
  endfunction

  function [15:0] res_mask;
    input [2:0] sel;
    begin
      res_mask = 16'hFFFF << (5'd16 - res_bits(sel));
    end
  endfunction

  function [3:0] max4;
    input [3:0] a;
    input [3:0] b;
    begin
      max4 = (a > b) ? a : b;
    end
  endfunction

  // registers
  reg        exc_source_reg;
  reg        sensor_type_reg;
  reg [2:0]  res_sel_reg;
  reg        fg_disable_reg;
  reg [3:0]  st_gain_reg;
  reg [3:0]  up_clamp_reg;
  reg [3:0]  lo_clamp_reg;
  reg [5:0]  enc_en_reg;
  reg        irq_en_reg;
  reg        hys_byp_reg;
  reg        lock_reg;
  reg        latch_sel_reg;
  reg [15:0] cmp_val_reg [0:2];
  reg [2:0]  flag_reg;
  reg        kick_reg;
  reg [2:0]  clr_reg;
  reg [19:0] fg_cnt_reg;
  reg [19:0] step_cnt_reg;
  reg [3:0]  gain_reg;
  reg        capped_reg;

  wire       wr_en;
  wire       rd_setup;
  wire [15:0] mask;
  wire       hyst_en;
  wire [3:0] match;
  wire [4:0] lsb;
  wire [15:0] shifted;
  reg  [31:0] rd_data;
  reg        rd_err;
  integer    i, j, k;

  assign wr_en    = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_setup = psel_i & ~penable_i;
  assign mask     = res_mask(res_sel_reg);
  assign hyst_en  = ~hys_byp_reg & (res_sel_reg == `RTAC_RES_12BIT);

  // three programmed compares plus the zero-angle compare for Z
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_cmp
      rtac_cmp u_cmp (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .angle_i   (angle_i),
        .target_i  ((g == 3) ? 16'h0000 : cmp_val_reg[g % 3]),
        .mask_i    (mask),
        .hyst_en_i (hyst_en),
        .match_o   (match[g])
      );
    end
  endgenerate

  // register read mux and unmapped decode
  always @*
  begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (paddr_i)
      `RTAC_EXC_CFG_OFS:  rd_data[1:0] = {sensor_type_reg, exc_source_reg};
      `RTAC_LOOP_CFG_OFS: rd_data[2:0] = res_sel_reg;
      `RTAC_DIAG_CTL_OFS: rd_data[15:0] = {lo_clamp_reg, up_clamp_reg, st_gain_reg,
                                           2'b00, fg_disable_reg, 1'b0};
      `RTAC_ENC_CTL_OFS:  rd_data[8:0] = {lock_reg, hys_byp_reg, irq_en_reg, enc_en_reg};
      `RTAC_CMP_CTL_OFS:  rd_data[10:0] = {flag_reg, 7'h00, latch_sel_reg};
      `RTAC_CMP0_OFS:     rd_data[15:0] = cmp_val_reg[0];
      `RTAC_CMP1_OFS:     rd_data[15:0] = cmp_val_reg[1];
      `RTAC_CMP2_OFS:     rd_data[15:0] = cmp_val_reg[2];
      `RTAC_STATUS_OFS:   rd_data[8:0] = {~exc_source_reg & ~sensor_type_reg,
                                          gain_reg, 3'h0, forced_gain_phase_o};
      default:            rd_err = 1'b1;
    endcase
  end

  // apb handshake: one cycle after setup the answer is ready
  always @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      pready_o  <= rd_setup;
      pslverr_o <= rd_setup & rd_err;
      if (rd_setup & ~pwrite_i)
        prdata_o <= rd_data;
    end
  end

  // software registers
  always @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      {sensor_type_reg, exc_source_reg} <= `RTAC_EXC_CFG_RST;
      res_sel_reg    <= `RTAC_RES_SEL_RST;
      fg_disable_reg <= 1'b0;
      st_gain_reg    <= `RTAC_ST_GAIN_RST;
      up_clamp_reg   <= `RTAC_UP_CLAMP_RST;
      lo_clamp_reg   <= `RTAC_LO_CLAMP_RST;
      enc_en_reg     <= `RTAC_ENC_EN_RST;
      irq_en_reg     <= 1'b0;
      hys_byp_reg    <= 1'b1;
      lock_reg       <= 1'b0;
      latch_sel_reg  <= 1'b0;
      kick_reg       <= 1'b0;
      clr_reg        <= 3'h0;
      for (i = 0; i < 3; i = i + 1)
        cmp_val_reg[i] <= 16'h0000;
    end
    else if (ce_i)
    begin
      kick_reg <= 1'b0;
      clr_reg  <= 3'h0;
      if (wr_en)
      begin
        case (paddr_i)
          `RTAC_EXC_CFG_OFS:  {sensor_type_reg, exc_source_reg} <= pwdata_i[1:0];
          `RTAC_LOOP_CFG_OFS: res_sel_reg <= pwdata_i[2:0];
          `RTAC_DIAG_CTL_OFS:
          begin
            kick_reg       <= pwdata_i[`RTAC_DIAG_KICK];
            fg_disable_reg <= pwdata_i[`RTAC_DIAG_DIS];
            st_gain_reg    <= pwdata_i[7:4];
            up_clamp_reg   <= pwdata_i[11:8];
            lo_clamp_reg   <= pwdata_i[15:12];
          end
          `RTAC_ENC_CTL_OFS:
          begin
            enc_en_reg  <= pwdata_i[5:0];
            irq_en_reg  <= pwdata_i[`RTAC_ENC_IRQ_EN];
            hys_byp_reg <= pwdata_i[`RTAC_ENC_HYS_BYP];
            lock_reg    <= pwdata_i[`RTAC_ENC_LOCK];
          end
          `RTAC_CMP_CTL_OFS:
          begin
            latch_sel_reg <= pwdata_i[`RTAC_CMP_LATCH];
            clr_reg       <= pwdata_i[6:4];
          end
          `RTAC_CMP0_OFS:     cmp_val_reg[0] <= pwdata_i[15:0];
          `RTAC_CMP1_OFS:     cmp_val_reg[1] <= pwdata_i[15:0];
          `RTAC_CMP2_OFS:     cmp_val_reg[2] <= pwdata_i[15:0];
          default:            ;
        endcase
      end
    end
  end

  // forced gain start decode
  wire       start_max;
  wire       start_short;
  wire       fg_start;
  wire [3:0] start_gain;
  wire [3:0] gain_ceil;

  assign start_max   = ~fg_disable_reg & (kick_reg | err_recover_i | conv_test_start_i
                                          | conv_test_end_i);
  assign start_short = ~fg_disable_reg & (short_test_end_i | short_detect_end_i);
  assign fg_start    = start_max | start_short;
  // a max start wins when both arrive together
  assign start_gain  = max4(start_max ? `RTAC_GAIN_MAX : st_gain_reg, lo_clamp_reg);
  assign gain_ceil   = capped_reg ? up_clamp_reg : `RTAC_GAIN_MAX;

  // forced gain sequencer
  always @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      // reset release always starts the phase, even when disabled
      forced_gain_phase_o <= 1'b1;
      fg_cnt_reg          <= FG_LOAD;
      step_cnt_reg        <= STEP_LOAD;
      gain_reg            <= `RTAC_GAIN_MAX;
      capped_reg          <= 1'b0;
    end
    else if (ce_i)
    begin
      if (fg_start)
      begin
        // restart the full interval from this cycle
        forced_gain_phase_o <= 1'b1;
        fg_cnt_reg          <= FG_LOAD;
        step_cnt_reg        <= STEP_LOAD;
        gain_reg            <= start_gain;
        capped_reg          <= 1'b0;
      end
      else if (forced_gain_phase_o)
      begin
        if (fg_cnt_reg == 20'd1)
          forced_gain_phase_o <= 1'b0;
        fg_cnt_reg <= fg_cnt_reg - 20'd1;
        if (gain_reg < up_clamp_reg)
          capped_reg <= 1'b1;
        if (step_cnt_reg == 20'd1)
        begin
          step_cnt_reg <= STEP_LOAD;
          if (gain_reg > lo_clamp_reg)
            gain_reg <= gain_reg - 4'h1;
        end
        else
        begin
          step_cnt_reg <= step_cnt_reg - 20'd1;
          if (gain_reg > gain_ceil)
            gain_reg <= gain_ceil;
        end
      end
    end
  end

  // compare flags: a new match wins over a clear in the same cycle
  always @(posedge mclk_i)
  begin
    if (!reset_n_i)
      flag_reg <= 3'h0;
    else if (ce_i)
    begin
      for (j = 0; j < 3; j = j + 1)
      begin
        if (latch_sel_reg & match[j])
          flag_reg[j] <= 1'b1;
        else if (clr_reg[j] & ~match[j])
          flag_reg[j] <= 1'b0;
      end
    end
  end

  // encoder phases from the converted angle
  wire [5:0] enc_raw;

  assign lsb     = 5'd16 - res_bits(res_sel_reg);
  assign shifted = angle_i >> lsb;
  // z takes the hysteresis path only when it is on; otherwise plain equality
  assign enc_raw[0] = shifted[1];
  assign enc_raw[1] = shifted[1] ^ shifted[0];
  assign enc_raw[2] = hyst_en ? match[3] : ((angle_i & mask) == 16'h0000);
  assign enc_raw[3] = angle_i < 16'h8000;
  assign enc_raw[4] = (angle_i >= 16'h5555) && (angle_i < 16'hD555);
  assign enc_raw[5] = (angle_i >= 16'hAAAA) || (angle_i < 16'h2AAB);

  // outputs, all registered
  always @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      velocity_gain_o         <= `RTAC_GAIN_MAX;
      resolution_select_o     <= `RTAC_RES_SEL_RST;
      excitation_out_en_o     <= 1'b0;
      extract_en_o            <= 1'b0;
      extract_use_recovered_o <= 1'b0;
      cmp_req_o               <= 3'h0;
      enc_pulse_o             <= 6'h00;
    end
    else if (ce_i)
    begin
      velocity_gain_o     <= gain_reg;
      resolution_select_o <= res_sel_reg;
      // only internal excitation drives the excitation pins
      excitation_out_en_o <= exc_source_reg & sensor_type_reg;
      extract_en_o        <= sensor_type_reg;
      extract_use_recovered_o <= sensor_type_reg & ~angle_err_large_i;
      for (k = 0; k < 3; k = k + 1)
        cmp_req_o[k] <= irq_en_reg & ~lock_reg
                        & (latch_sel_reg ? (flag_reg[k] | match[k]) : match[k]);
      enc_pulse_o <= lock_reg ? 6'h00 : (enc_raw & enc_en_reg);
    end
  end

endmodule // rtac_top

// *** verification/rtac_sensor_model.sv ***
// resolver sensor as seen through the converter: converted angle chases the rotor
module rtac_sensor_model (
  // clock
  input  wire logic        clk_i,
  // rotor position and slew mode
  input  wire logic [15:0] rotor_i,
  input  wire logic        fast_i,
  // converted angle and tracking error
  output logic      [15:0] angle_o,
  output logic             err_large_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] gap;
  assign gap = rotor_i - angle_o;
  initial angle_o = 16'h0000;
  initial err_large_o = 1'b0;
  always @(posedge clk_i)
  begin
    // slow mode slews one fixed step a cycle, well under the speed limit
    if (fast_i)
      angle_o <= rotor_i;
    else if (gap != 16'h0000)
      angle_o <= gap[15] ? angle_o - 16'h0100 : angle_o + 16'h0100;
    err_large_o <= !fast_i && (gap[15] ? -gap : gap) > 16'h0800;
  end
endmodule // rtac_sensor_model

// *** verification/rtac_top_sva.sv ***
// assertion checker bound to the top of the forced gain and compare block
module rtac_top_sva #(
  parameter FG_CYCLES = 50000
) (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // events and loop outputs
  input wire logic        angle_err_large_i,
  input wire logic        conv_test_start_i,
  input wire logic        short_test_end_i,
  input wire logic        short_detect_end_i,
  input wire logic        forced_gain_phase_o,
  input wire logic [3:0]  velocity_gain_o,
  input wire logic [2:0]  resolution_select_o,
  input wire logic        excitation_out_en_o,
  input wire logic        extract_en_o,
  input wire logic        extract_use_recovered_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // length of the current forced phase, so short phases are caught
  logic [31:0] run_q;
  always @(posedge mclk_i)
    run_q <= (!reset_n_i || !forced_gain_phase_o) ? 32'h0 : run_q + 32'h1;

  property p_reset_start;
    $rose(reset_n_i) |-> forced_gain_phase_o && velocity_gain_o == 4'h7;
  endproperty
  a_reset_start: assert property (p_reset_start) else $error("no phase at reset release");
  property p_span;
    $fell(forced_gain_phase_o) |-> run_q >= FG_CYCLES - 2;
  endproperty
  a_span: assert property (p_span) else $error("forced phase too short");
  property p_conv_gain;
    $rose(forced_gain_phase_o) && $past(conv_test_start_i) |=> velocity_gain_o == 4'h7;
  endproperty
  a_conv_gain: assert property (p_conv_gain) else $error("conversion test gain not max");
  property p_decay;
    velocity_gain_o < $past(velocity_gain_o) && !$past(short_test_end_i, 2)
      && !$past(short_detect_end_i, 2) |-> velocity_gain_o == $past(velocity_gain_o) - 4'h1;
  endproperty
  a_decay: assert property (p_decay) else $error("gain dropped more than one step");
  property p_dc_off;
    excitation_out_en_o |-> extract_en_o;
  endproperty
  a_dc_off: assert property (p_dc_off) else $error("excitation on without sensor type");
  property p_recovered;
    extract_use_recovered_o |-> extract_en_o && !$past(angle_err_large_i);
  endproperty
  a_recovered: assert property (p_recovered) else $error("recovered used on large error");
  property p_res;
    $changed(resolution_select_o) |-> $past(psel_i && penable_i && pwrite_i && paddr_i == 8'h04)
      || $past(psel_i && penable_i && pwrite_i && paddr_i == 8'h04, 2);
  endproperty
  a_res: assert property (p_res) else $error("resolution changed without write");
  property p_ready;
    psel_i && !penable_i |=> pready_o ##1 !pready_o;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer not one cycle");
  property p_err;
    pslverr_o |-> pready_o;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
endmodule // rtac_top_sva

bind rtac_top rtac_top_sva #(.FG_CYCLES(FG_CYCLES)) sva_u (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .angle_err_large_i(angle_err_large_i), .conv_test_start_i(conv_test_start_i),
  .short_test_end_i(short_test_end_i), .short_detect_end_i(short_detect_end_i),
  .forced_gain_phase_o(forced_gain_phase_o), .velocity_gain_o(velocity_gain_o),
  .resolution_select_o(resolution_select_o), .excitation_out_en_o(excitation_out_en_o),
  .extract_en_o(extract_en_o), .extract_use_recovered_o(extract_use_recovered_o));

// *** verification/rtac_top_tb_top.sv ***
// self-checking bench for the forced gain, excitation and compare block
module rtac_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FG = 40;
  logic        mclk_i = 0;
  logic        reset_n_i = 0;
  logic        psel = 0, penable = 0, pwrite = 0, fast = 1, ce = 1;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [15:0] rotor = 0, angle;
  logic [4:0]  evt = 0;
  logic        pready, pslverr, err_large, phase, exc_en, ext_en, ext_rec, last_err;
  logic [3:0]  gain;
  logic [2:0]  res, req;
  logic [5:0]  enc;
  int          mismatches = 0, samples_checked = 0, ticks = 0, run = 0, last = 0;

  always #50 mclk_i = ~mclk_i;

  rtac_sensor_model model_u (.clk_i(mclk_i), .rotor_i(rotor), .fast_i(fast),
    .angle_o(angle), .err_large_o(err_large));
  rtac_top #(.FG_CYCLES(FG), .STEP_CYCLES(4)) dut_u (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .angle_i(angle),
    .angle_err_large_i(err_large), .err_recover_i(evt[0]), .conv_test_start_i(evt[1]),
    .conv_test_end_i(evt[2]), .short_test_end_i(evt[3]), .short_detect_end_i(evt[4]),
    .forced_gain_phase_o(phase), .velocity_gain_o(gain), .resolution_select_o(res),
    .excitation_out_en_o(exc_en), .extract_en_o(ext_en),
    .extract_use_recovered_o(ext_rec), .cmp_req_o(req), .enc_pulse_o(enc));

  task automatic wrap_up;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // apb transfer: request held until pready is sampled high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(q, e);
  endtask
  task automatic ev(input int i);
    @(posedge mclk_i);
    evt[i] <= 1;
    @(posedge mclk_i);
    evt <= 0;
  endtask
  task automatic idle;
    cyc(2);
    while (phase !== 1'b0) cyc(1);
    cyc(2);
  endtask
  task automatic at(input logic [15:0] a);
    rotor <= a;
    cyc(4);
  endtask

  // phase run length monitor and hang guard
  always @(posedge mclk_i)
  begin
    ticks <= ticks + 1;
    run <= (phase && reset_n_i) ? run + 1 : 0;
    if (!phase && run != 0)
      last <= run;
    if (ticks > 20000)
    begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end

  initial
  begin
    cyc(20);
    reset_n_i <= 1;
    cyc(1);
    chk(gain, 7);
    rd(8'h00, 32'h3);
    rd(8'h04, 32'h1);
    rd(8'h08, 32'h740);
    rd(8'h0C, 32'h80);
    rd(8'h10, 32'h0);
    rd(8'h24, 32'h0);
    chk(last_err, 1);
    idle;
    chk(last >= FG && last <= FG + 1, 1);
    bus(1, 8'h08, 32'h3741);
    cyc(2);
    chk(phase, 1);
    idle;
    chk(gain, 3);
    rd(8'h08, 32'h3740);
    rd(8'h20, 32'h30);
    bus(1, 8'h08, 32'h0720);
    for (int i = 0; i < 5; i++)
    begin
      ev(i);
      cyc(2);
      chk(phase, 1);
      chk(gain, i > 2 ? 2 : 7);
      idle;
    end
    ev(0);
    cyc(20);
    ev(0);
    idle;
    chk(last >= FG + 20 && last <= FG + 24, 1);
    // disable only at standstill, then kick
    bus(1, 8'h08, 32'h0722);
    ev(3);
    bus(1, 8'h08, 32'h0723);
    cyc(3);
    chk(phase, 0);
    bus(1, 8'h08, 32'h0720);
    bus(1, 8'h08, 32'h0721);
    cyc(2);
    chk(phase, 1);
    // enable low freezes the phase count and the gain decay
    ce <= 0;
    cyc(50);
    chk(phase, 1);
    chk(gain, 7);
    ce <= 1;
    idle;
    fast <= 0;
    rotor <= 16'h8000;
    for (int v = 0; v < 4; v++)
    begin
      bus(1, 8'h00, 32'(v));
      cyc(2);
      chk(exc_en, v == 3);
      chk(ext_en, v[1]);
      chk(ext_rec, 0);
      bus(0, 8'h20, 0);
      chk(q[8], v == 0);
    end
    fast <= 1;
    cyc(4);
    chk(ext_rec, 1);
    bus(1, 8'h0C, 32'hC0);
    bus(1, 8'h14, 32'h0100);
    bus(1, 8'h18, 32'h0200);
    bus(1, 8'h1C, 32'h0200);
    at(16'h0105);
    chk(req, 3'b001);
    bus(1, 8'h04, 32'h4);
    cyc(4);
    chk(res, 4);
    chk(req, 0);
    bus(1, 8'h04, 32'h1);
    at(16'h0200);
    chk(req, 3'b110);
    bus(1, 8'h0C, 32'h80);
    cyc(3);
    chk(req, 0);
    bus(1, 8'h0C, 32'hC0);
    at(16'h0300);
    bus(1, 8'h10, 32'h71);
    at(16'h0100);
    at(16'h0300);
    chk(req, 3'b001);
    rd(8'h10, 32'h101);
    at(16'h0100);
    bus(1, 8'h10, 32'h11);
    cyc(3);
    chk(req, 3'b001);
    rd(8'h10, 32'h101);
    at(16'h0300);
    bus(1, 8'h10, 32'h11);
    cyc(3);
    chk(req, 0);
    rd(8'h10, 32'h1);
    bus(1, 8'h0C, 32'hBF);
    at(16'h0000);
    chk(enc, 6'h2C);
    bus(1, 8'h0C, 32'h1BF);
    cyc(3);
    chk(enc, 0);
    bus(1, 8'h0C, 32'h80);
    cyc(3);
    chk(enc, 0);
    bus(1, 8'h0C, 32'h3F);
    cyc(3);
    chk(enc[2], 1);
    at(16'h0010);
    chk(enc[2], 1);
    chk(enc[1:0], 2'b10);
    at(16'h0020);
    chk(enc[2], 0);
    wrap_up;
  end
endmodule // rtac_top_tb_top
